/* iodr_defs.svh */
// register offsets, field widths and full-scale codes of the inertial output bank
// assumes byte addressing with 16-bit registers on even addresses
`ifndef IODR_DEFS_SVH
`define IODR_DEFS_SVH
`define IODR_ADDR_W 7
`define IODR_X_RATE_FRACTION 7'h04
`define IODR_X_RATE_WORD 7'h06
`define IODR_Y_RATE_FRACTION 7'h08
`define IODR_Y_RATE_WORD 7'h0a
`define IODR_Z_RATE_FRACTION 7'h0c
`define IODR_Z_RATE_WORD 7'h0e
`define IODR_X_ACCEL_FRACTION 7'h10
`define IODR_X_ACCEL_WORD 7'h12
`define IODR_Y_ACCEL_FRACTION 7'h14
`define IODR_Y_ACCEL_WORD 7'h16
`define IODR_N_CHAN 5
`define IODR_LAST_CHAN 3'h4
`define IODR_RATE_POS_FS 16'h4e20
`define IODR_RATE_NEG_FS 16'hb1e0
`define IODR_ACCEL_POS_FS 16'h7d00
`define IODR_ACCEL_NEG_FS 16'h8300
`define IODR_UNMAPPED_DATA 16'h0000
`endif

/* iodr_pkg.sv */
// types shared by the inertial output register bank
// no assumptions beyond a SystemVerilog compiler
package iodr_pkg;
	typedef logic [31:0] iodr_sample_t;
	typedef enum logic [2:0] {IODR_RX, IODR_RY, IODR_RZ, IODR_AX, IODR_AY} iodr_chan_t;
	typedef enum logic {IODR_IDLE, IODR_COPY} iodr_wr_state_t;
endpackage

/* iodr_store.sv */
// holds the five 32-bit measurements; read word comes out of a register, zero when idle
// assumes one write port from the sample path and one read port from the host
`timescale 1ns/1ns
`default_nettype none
`include "iodr_defs.svh"
module iodr_store #(
	parameter int DEPTH = 5
) (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [2:0] wr_idx,
	input wire logic [31:0] wr_data,
	input wire logic rd_en,
	input wire logic [2:0] rd_idx,
	input wire logic rd_hi,
	output logic [15:0] rd_data
);
	logic [31:0] mem [DEPTH];

	// no reset: contents are undefined until the first sample
	always_ff @(posedge clk)
	begin
		if (wr_en)
			mem[wr_idx] <= wr_data;
	end

	always_ff @(posedge clk)
	begin
		if (rd_en)
			rd_data <= rd_hi ? mem[rd_idx][31:16] : mem[rd_idx][15:0];
		else
			rd_data <= `IODR_UNMAPPED_DATA;
	end
endmodule
`default_nettype wire

/* iodr_bank.sv */
// read-only bank of rate and acceleration outputs, host reads by address
// assumes sample path presents signed 32-bit values, saturated here to full scale, with a one-cycle strobe
// Notes on behaviour
// - each axis has high word over low word forming one 32-bit value
// - rate high word is twos complement, zero rotation reads zero
// - low word holds sixteen extra resolution bits below the high word
// - acceleration high word twos complement, 1.25 mg per count
// - acceleration full scale reads 0x7d00 and 0x8300
// - rate registers sit at 0x04 through 0x0e
// - acceleration registers sit at 0x10 through 0x16
// - registers are read only, no reset value, writes ignored
// - rate full scale reads 0x4e20 and 0xb1e0
`timescale 1ns/1ns
`default_nettype none
`include "iodr_defs.svh"
module iodr_bank (
	input wire logic clk,
	input wire logic rst_n,
	// sample path, one strobe per new set of measurements
	input wire logic sample_valid,
	input wire logic [31:0] x_rate_in,
	input wire logic [31:0] y_rate_in,
	input wire logic [31:0] z_rate_in,
	input wire logic [31:0] x_accel_in,
	input wire logic [31:0] y_accel_in,
	// host read port; writes are accepted and dropped
	input wire logic rd_req,
	input wire logic wr_req,
	input wire logic [`IODR_ADDR_W-1:0] addr,
	// answer one cycle after an accepted read
	output logic [15:0] rd_data,
	output logic rd_valid,
	output logic addr_hit
);
	// copy sequencer
	logic [2:0] wr_cnt_r;
	iodr_pkg::iodr_wr_state_t wr_state_r;
	iodr_pkg::iodr_wr_state_t wr_state_nxt;
	logic copying;
	logic sample_take;
	iodr_pkg::iodr_sample_t hold_r [`IODR_N_CHAN];
	iodr_pkg::iodr_sample_t wr_word;

	// read side
	logic rd_take;
	logic rd_valid_r;
	logic hit_r;
	logic [2:0] rd_idx;
	logic rd_hi;
	logic hit;
	logic [15:0] store_q;

	function automatic logic [31:0] clamp(input logic [31:0] v, input logic [15:0] pos,
		input logic [15:0] neg);
		logic [31:0] res;
		res = v;
		// saturate so the high word never passes the full-scale codes
		if ($signed(v) > $signed({pos, 16'h0000}))
			res = {pos, 16'h0000};
		else if ($signed(v) < $signed({neg, 16'h0000}))
			res = {neg, 16'h0000};
		return res;
	endfunction

	// decode: 0x04..0x16 even addresses map to five channels, bit 1 picks high word
	always_comb
	begin
		hit = 1'b0;
		rd_idx = 3'h0;
		rd_hi = addr[1];
		case ({addr[6:2], 2'b00})
			`IODR_X_RATE_FRACTION:
			begin
				hit = 1'b1;
				rd_idx = 3'(iodr_pkg::IODR_RX);
			end
			`IODR_Y_RATE_FRACTION:
			begin
				hit = 1'b1;
				rd_idx = 3'(iodr_pkg::IODR_RY);
			end
			`IODR_Z_RATE_FRACTION:
			begin
				hit = 1'b1;
				rd_idx = 3'(iodr_pkg::IODR_RZ);
			end
			`IODR_X_ACCEL_FRACTION:
			begin
				hit = 1'b1;
				rd_idx = 3'(iodr_pkg::IODR_AX);
			end
			`IODR_Y_ACCEL_FRACTION:
			begin
				hit = 1'b1;
				rd_idx = 3'(iodr_pkg::IODR_AY);
			end
			default:
				hit = 1'b0;
		endcase
		// odd byte addresses split a register and map to nothing
		if (addr[0])
			hit = 1'b0;
	end

	// a strobe is taken only when the previous sample is fully stored
	assign sample_take = sample_valid && !copying;
	// a write in the same cycle cancels the read; writes never reach the store
	assign rd_take = rd_req && !wr_req;

	// capture all channels at one strobe, then write them one per cycle
	always_ff @(posedge clk)
	begin
		if (sample_take)
		begin
			hold_r[0] <= clamp(x_rate_in, `IODR_RATE_POS_FS, `IODR_RATE_NEG_FS);
			hold_r[1] <= clamp(y_rate_in, `IODR_RATE_POS_FS, `IODR_RATE_NEG_FS);
			hold_r[2] <= clamp(z_rate_in, `IODR_RATE_POS_FS, `IODR_RATE_NEG_FS);
			hold_r[3] <= clamp(x_accel_in, `IODR_ACCEL_POS_FS, `IODR_ACCEL_NEG_FS);
			hold_r[4] <= clamp(y_accel_in, `IODR_ACCEL_POS_FS, `IODR_ACCEL_NEG_FS);
		end
	end

	// copy sequencer: idle until a strobe, then one channel per cycle
	always_comb
	begin
		wr_state_nxt = wr_state_r;
		case (wr_state_r)
			iodr_pkg::IODR_IDLE:
			begin
				if (sample_valid)
					wr_state_nxt = iodr_pkg::IODR_COPY;
			end
			iodr_pkg::IODR_COPY:
			begin
				if (wr_cnt_r == `IODR_LAST_CHAN)
					wr_state_nxt = iodr_pkg::IODR_IDLE;
			end
			default:
				wr_state_nxt = iodr_pkg::IODR_IDLE;
		endcase
	end

	// sequencer state, cleared by reset
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			wr_state_r <= iodr_pkg::IODR_IDLE;
		else
			wr_state_r <= wr_state_nxt;
	end

	assign copying = (wr_state_r == iodr_pkg::IODR_COPY);

	// channel index, zero after reset and parked past the last channel after each copy
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			wr_cnt_r <= 3'h0;
		else if (sample_take)
			wr_cnt_r <= 3'h0;
		else if (copying)
			wr_cnt_r <= wr_cnt_r + 3'h1;
	end

	// parked index reads zero, never an out-of-range unknown
	always_comb
	begin
		wr_word = 32'h0000_0000;
		case (wr_cnt_r)
			3'h0:
				wr_word = hold_r[0];
			3'h1:
				wr_word = hold_r[1];
			3'h2:
				wr_word = hold_r[2];
			3'h3:
				wr_word = hold_r[3];
			3'h4:
				wr_word = hold_r[4];
			default:
				wr_word = 32'h0000_0000;
		endcase
	end

	// both halves written in one 32-bit word; fraction fills the low 16 bits
	// a host reading the two words across a strobe may still mix samples
	iodr_store #(
		.DEPTH(`IODR_N_CHAN)
	) u_store (
		.clk(clk),
		.wr_en(copying),
		.wr_idx(wr_cnt_r),
		.wr_data(wr_word),
		.rd_en(rd_take && hit && rst_n),
		.rd_idx(rd_idx),
		.rd_hi(rd_hi),
		.rd_data(store_q)
	);

	// answer strobe one cycle after every accepted read, mapped or not
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rd_valid_r <= 1'b0;
		else
			rd_valid_r <= rd_take;
	end

	// mapped flag of the last presented address
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			hit_r <= 1'b0;
		else
			hit_r <= hit;
	end

	assign rd_valid = rd_valid_r;
	assign addr_hit = hit_r;
	// store register returns zero on idle and unmapped cycles
	assign rd_data = store_q;
endmodule
`default_nettype wire

/* iodr_bank_assertions.sv */
// checker on the read port of the output bank
// assumes it is bound into every bank instance
`timescale 1ns/1ns
`default_nettype none
module iodr_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic rd_req,
	input wire logic wr_req,
	input wire logic [6:0] addr,
	input wire logic [15:0] rd_data,
	input wire logic rd_valid,
	input wire logic addr_hit
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic rd = rd_req && !wr_req;
	a_read_ans: assert property (rd |=> rd_valid) else $error("no answer");
	a_valid_cause: assert property (rd_valid |-> $past(rd)) else $error("stray valid");
	a_idle_zero: assert property (!rd_valid |-> rd_data == 16'h0000) else $error("idle data");
	a_miss_zero: assert property (rd_valid && !addr_hit |-> rd_data == 16'h0000) else $error("miss data");
	a_odd_miss: assert property (rd && addr[0] |=> !addr_hit) else $error("odd hit");
	a_hit_map: assert property (rd && !addr[0] && addr >= 7'h04 && addr <= 7'h16 |=> addr_hit) else $error("no hit");
	a_high_miss: assert property (rd && addr > 7'h16 |=> !addr_hit) else $error("high hit");
	a_low_miss: assert property (rd && addr < 7'h04 |=> !addr_hit) else $error("low hit");
endmodule
bind iodr_bank iodr_chk u_chk (.clk(clk), .rst_n(rst_n), .rd_req(rd_req), .wr_req(wr_req),
	.addr(addr), .rd_data(rd_data), .rd_valid(rd_valid), .addr_hit(addr_hit));
`default_nettype wire

/* iodr_host.sv */
// host model: puts bench reads on the port
// assumes go and a change off the clock edge
`timescale 1ns/1ns
`default_nettype none
module iodr_host (
	input wire logic go,
	input wire logic [6:0] a,
	output logic rd_req,
	output logic [6:0] addr
);
	assign rd_req = go;
	assign addr = a;
endmodule
`default_nettype wire

/* iodr_bank_test.sv */
// bench: samples in, every word read back
// assumes bank, checker and host model compiled first
`timescale 1ns/1ns
`default_nettype none
module iodr_bank_test;
	logic clk = 0, rst_n = 0, sv = 0, go = 0, wr = 0;
	logic [6:0] a = 7'h00;
	logic [31:0] s = 32'h0000f45b, d [5] = '{default: 32'h0}, e [5];
	logic [16:0] q [$];
	logic [16:0] cur;
	int n_mismatch = 0, tests_run = 0;
	wire logic rq, rv, hit;
	wire logic [6:0] ad;
	wire logic [15:0] rdat;
	initial forever #4 clk = ~clk;
	iodr_host HOST (.go(go), .a(a), .rd_req(rq), .addr(ad));
	iodr_bank DUT (.clk(clk), .rst_n(rst_n), .sample_valid(sv), .x_rate_in(d[0]),
		.y_rate_in(d[1]), .z_rate_in(d[2]), .x_accel_in(d[3]), .y_accel_in(d[4]),
		.rd_req(rq), .wr_req(wr), .addr(ad), .rd_data(rdat), .rd_valid(rv), .addr_hit(hit));
	function automatic logic [31:0] xs(logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	task automatic complete_run;
		if (n_mismatch == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(logic [15:0] x);
		tests_run++;
		if (rdat !== x)
		begin
			n_mismatch++;
			$display("MISMATCH rd_data exp %h got %h", x, rdat);
		end
	endtask
	task automatic chk_hit(logic x);
		tests_run++;
		if (hit !== x)
		begin
			n_mismatch++;
			$display("MISMATCH addr_hit exp %h got %h", x, hit);
		end
	endtask
	always @(negedge clk)
		if (rv === 1'b1)
		begin
			cur = q.size() > 0 ? q.pop_front() : {1'bx, 16'hxxxx};
			chk(cur[15:0]);
			chk_hit(cur[16]);
		end
	// m: 0 in range, 1 below and 2 above full scale
	task automatic smp(int m);
		for (int i = 0; i < 5; i++)
		begin
			s = xs(s);
			d[i] = m == 0 ? {{3{s[29]}}, s[28:0]} : {m == 1, {31{m == 2}}};
			e[i] = m == 0 ? d[i] : {m == 1 ? (i < 3 ? 16'hb1e0 : 16'h8300) :
				(i < 3 ? 16'h4e20 : 16'h7d00), 16'h0000};
		end
		sv = 1;
		@(negedge clk);
		sv = 0;
		repeat (6) @(negedge clk);
	endtask
	initial
	begin
		repeat (3) @(negedge clk);
		rst_n = 1;
		for (int m = 0; m < 4; m++)
		begin
			smp(m % 3);
			wr = 1;
			go = 1;
			a = 7'h06;
			@(negedge clk);
			wr = 0;
			for (int k = 0; k < 14; k++)
			begin
				a = k < 10 ? 7'(4 + 2 * k) : 7'(k * 13 - 130);
				q.push_back({k < 10, k < 10 ? e[k / 2][k % 2 * 16 +: 16] : 16'h0000});
				@(negedge clk);
			end
			go = 0;
		end
		repeat (2) @(negedge clk);
		if (q.size() != 0)
		begin
			n_mismatch++;
			$display("MISMATCH pending_reads exp 0 got %0d", q.size());
		end
		complete_run();
	end
	initial
	begin
		repeat (2000) @(posedge clk);
		n_mismatch++;
		$display("MISMATCH run_end exp finished got timeout");
		complete_run();
	end
endmodule
`default_nettype wire
